// ===== hdl/fp_compare_mask_unit.sv
// Purpose: Scalar floating-point compare producing an all-ones or all-zeros mask.
// Assumes: Issue inputs are synchronous to i_core_clk; one instruction per cycle at most.
// Notes:   Result and exception appear one cycle after issue; registers on AXI4-Lite.
//
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/100ps

// Notes on behaviour
// RL1: Decode compare by major opcode 010001.
// RL2: Any NaN forces unordered true, others false.
// RL3: Invalid on signalling NaN, or signalling quiet NaN.
// RL4: Non-NaN: numeric less and equal, unordered false.
// RL5: Result is bit4 xor selected relation terms.
// RL6: Write result replicated as full-width mask.
// RL7: Upper bits 00 select direct predicates.
// RL8: Upper bits 01 select negated predicates.
// RL9: Reserved condition encodings are rejected.
// RL10: Unimplemented and invalid operation exceptions supported.
// RL11: Unusable when FP disabled; reserved on bad encoding.
// RL12: Invalid sets flag; enabled trap suppresses write.
// RL13: Positive and negative zero compare equal.
// RL14: Only single and double formats accepted.
module fp_compare_mask_unit (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // Issue side
  input wire logic i_issue_valid,
  input wire logic [31:0] i_instr,
  input wire logic [63:0] i_first_source_operand,
  input wire logic [63:0] i_second_source_operand,
  input wire logic i_fp_usable,
  // Result side
  output logic o_result_valid,
  output logic o_result_write,
  output logic [4:0] o_destination_register,
  output logic [63:0] o_result_data,
  output logic o_exc_valid,
  output logic [2:0] o_exc_code,
  // AXI4-Lite write address and data
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [7:0] i_s_axi_awaddr,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  // AXI4-Lite write response
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  output logic [1:0] o_s_axi_bresp,
  // AXI4-Lite read
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  input wire logic [7:0] i_s_axi_araddr,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  // Interrupt
  output logic o_irq
);

  // ****************************************
  // Instruction fields
  // ****************************************
  logic [5:0] opcode;
  logic [4:0] fmt_field;
  logic [5:0] func_field;
  logic [4:0] dest_field;
  logic is_double;
  logic fmt_ok;
  logic cond_ok;
  logic less;
  logic equal;
  logic unordered;
  logic snan_any;
  logic qnan_any;
  logic sub_any;
  logic invalid_cond;
  logic predicate;
  fp_cmp_pkg::exc_code_t exc_next;
  logic write_next;

  assign opcode = i_instr[fp_cmp_pkg::OPC_MSB:fp_cmp_pkg::OPC_LSB];
  assign fmt_field = i_instr[fp_cmp_pkg::FMT_MSB:fp_cmp_pkg::FMT_LSB];
  assign func_field = i_instr[5:0];
  assign dest_field = i_instr[fp_cmp_pkg::DEST_LSB +: 5];
  assign is_double = (fmt_field == fp_cmp_pkg::FMT_DOUBLE);
  assign fmt_ok = (fmt_field == fp_cmp_pkg::FMT_SINGLE) || is_double; // RL14

  // Negated forms exist only for ordered, unordered-or-not-equal and not-equal
  always_comb begin
    if (!func_field[fp_cmp_pkg::COND_NEG]) begin
      cond_ok = 1'b1; // RL7
    end else if ((func_field[2:0] >= 3'h1) && (func_field[2:0] <= 3'h3)) begin
      cond_ok = 1'b1; // RL8
    end else begin
      cond_ok = 1'b0; // RL9
    end
  end

  fp_order_compare u_order (
    .i_op_a(i_first_source_operand),
    .i_op_b(i_second_source_operand),
    .i_double(is_double),
    .o_less(less),
    .o_equal(equal),
    .o_unordered(unordered),
    .o_snan_any(snan_any),
    .o_qnan_any(qnan_any),
    .o_sub_any(sub_any)
  );

  assign invalid_cond = snan_any ||
    (func_field[fp_cmp_pkg::COND_SIG] && qnan_any); // RL3

  assign predicate = func_field[fp_cmp_pkg::COND_NEG] ^ (
    (func_field[fp_cmp_pkg::COND_LT] && less) ||
    (func_field[fp_cmp_pkg::COND_EQ] && equal) ||
    (func_field[fp_cmp_pkg::COND_UN] && unordered)); // RL5

  // ****************************************
  // Register file state
  // ****************************************
  logic [1:0] ctrl_reg;
  logic [3:0] status_reg;
  logic [3:0] mask_reg;
  logic [31:0] count_reg;
  logic last_result_reg;
  logic [3:0] event_set;
  logic [3:0] status_clear;

  // Exception priority: unusable, reserved encoding, unimplemented, invalid
  always_comb begin
    exc_next = fp_cmp_pkg::EXC_NONE;
    write_next = 1'b0;
    if (!i_fp_usable) begin
      exc_next = fp_cmp_pkg::EXC_UNUSABLE; // RL11
    end else if ((opcode != fp_cmp_pkg::OPC_COP1) || func_field[fp_cmp_pkg::FUNC_TOP]) begin
      exc_next = fp_cmp_pkg::EXC_RSVD_INSTR; // RL1
    end else if (!fmt_ok || !cond_ok) begin
      exc_next = fp_cmp_pkg::EXC_RSVD_INSTR; // RL11
    end else if (sub_any && ctrl_reg[fp_cmp_pkg::CTRL_SUB_TRAP]) begin
      exc_next = fp_cmp_pkg::EXC_UNIMPL_OP; // RL10
    end else if (invalid_cond && ctrl_reg[fp_cmp_pkg::CTRL_INV_EN]) begin
      exc_next = fp_cmp_pkg::EXC_INVALID_OP; // RL12
    end else begin
      write_next = 1'b1; // RL12
    end
  end

  // ****************************************
  // Result stage
  // ****************************************
  // Strobes last one cycle; mask and index hold until the next write
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_result_valid <= 1'b0;
      o_result_write <= 1'b0;
      o_exc_valid <= 1'b0;
      o_exc_code <= fp_cmp_pkg::EXC_NONE;
    end else begin
      o_result_valid <= i_issue_valid;
      o_result_write <= i_issue_valid && write_next;
      o_exc_valid <= i_issue_valid && (exc_next != fp_cmp_pkg::EXC_NONE); // RL10
      o_exc_code <= i_issue_valid ? exc_next : fp_cmp_pkg::EXC_NONE;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_destination_register <= 5'h00;
      o_result_data <= 64'h0;
    end else if (i_issue_valid && write_next) begin
      o_destination_register <= dest_field;
      o_result_data <= {64{predicate}}; // RL6
    end
  end

  // Counts written masks only; trapped or refused instructions are not counted
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      count_reg <= 32'h0;
      last_result_reg <= 1'b0;
    end else if (i_issue_valid && write_next) begin
      count_reg <= count_reg + 32'h1;
      last_result_reg <= predicate;
    end
  end

  // ****************************************
  // Sticky status and interrupt
  // ****************************************
  // Invalid flag is raised whether or not its trap is enabled
  always_comb begin
    event_set = 4'h0;
    if (i_issue_valid) begin
      event_set[fp_cmp_pkg::ST_INVALID] = (exc_next == fp_cmp_pkg::EXC_INVALID_OP) ||
        (write_next && invalid_cond); // RL12
      event_set[fp_cmp_pkg::ST_RSVD] = (exc_next == fp_cmp_pkg::EXC_RSVD_INSTR);
      event_set[fp_cmp_pkg::ST_UNUSABLE] = (exc_next == fp_cmp_pkg::EXC_UNUSABLE);
      event_set[fp_cmp_pkg::ST_UNIMPL] = (exc_next == fp_cmp_pkg::EXC_UNIMPL_OP);
    end
  end

  // Set beats a simultaneous write-one clear so no event is lost
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      status_reg <= fp_cmp_pkg::STATUS_RESET;
    end else begin
      status_reg <= (status_reg & ~status_clear) | event_set;
    end
  end

  // Level output; it falls only when software clears status or mask
  assign o_irq = |(status_reg & mask_reg);

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_fire;
  logic waddr_known;

  // Address and data are latched apart, so either may come first
  assign o_s_axi_awready = !aw_held_reg && !o_s_axi_bvalid;
  assign o_s_axi_wready = !w_held_reg && !o_s_axi_bvalid;
  assign wr_fire = aw_held_reg && w_held_reg && !o_s_axi_bvalid;

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      aw_held_reg <= 1'b0;
      waddr_reg <= 8'h00;
    end else if (i_s_axi_awvalid && o_s_axi_awready) begin
      aw_held_reg <= 1'b1;
      waddr_reg <= i_s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      w_held_reg <= 1'b0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
    end else if (i_s_axi_wvalid && o_s_axi_wready) begin
      w_held_reg <= 1'b1;
      wdata_reg <= i_s_axi_wdata;
      wstrb_reg <= i_s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  // Unmapped offsets answer with an error and change nothing
  always_comb begin
    if (waddr_reg == fp_cmp_pkg::ADDR_CTRL) begin
      waddr_known = 1'b1;
    end else if (waddr_reg == fp_cmp_pkg::ADDR_STATUS) begin
      waddr_known = 1'b1;
    end else if (waddr_reg == fp_cmp_pkg::ADDR_MASK) begin
      waddr_known = 1'b1;
    end else if (waddr_reg == fp_cmp_pkg::ADDR_COUNT) begin
      waddr_known = 1'b1;
    end else if (waddr_reg == fp_cmp_pkg::ADDR_LAST) begin
      waddr_known = 1'b1;
    end else begin
      waddr_known = 1'b0;
    end
  end

  always_comb begin
    status_clear = 4'h0;
    if (wr_fire && (waddr_reg == fp_cmp_pkg::ADDR_STATUS) && wstrb_reg[0]) begin
      status_clear = wdata_reg[3:0];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      ctrl_reg <= fp_cmp_pkg::CTRL_RESET;
      mask_reg <= fp_cmp_pkg::MASK_RESET;
    end else if (wr_fire && wstrb_reg[0]) begin
      if (waddr_reg == fp_cmp_pkg::ADDR_CTRL) begin
        ctrl_reg <= wdata_reg[1:0];
      end else if (waddr_reg == fp_cmp_pkg::ADDR_MASK) begin
        mask_reg <= wdata_reg[3:0];
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= fp_cmp_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      o_s_axi_bvalid <= 1'b1;
      if (waddr_known) begin
        o_s_axi_bresp <= fp_cmp_pkg::RESP_OKAY;
      end else begin
        o_s_axi_bresp <= fp_cmp_pkg::RESP_SLVERR;
      end
    end else if (i_s_axi_bready) begin
      o_s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  // One read outstanding: arready falls while the answer waits
  assign o_s_axi_arready = !o_s_axi_rvalid;

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h0;
      o_s_axi_rresp <= fp_cmp_pkg::RESP_OKAY;
    end else if (i_s_axi_arvalid && o_s_axi_arready) begin
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rresp <= fp_cmp_pkg::RESP_OKAY;
      if (i_s_axi_araddr == fp_cmp_pkg::ADDR_CTRL) begin
        o_s_axi_rdata <= {30'h0, ctrl_reg};
      end else if (i_s_axi_araddr == fp_cmp_pkg::ADDR_STATUS) begin
        o_s_axi_rdata <= {28'h0, status_reg};
      end else if (i_s_axi_araddr == fp_cmp_pkg::ADDR_MASK) begin
        o_s_axi_rdata <= {28'h0, mask_reg};
      end else if (i_s_axi_araddr == fp_cmp_pkg::ADDR_COUNT) begin
        o_s_axi_rdata <= count_reg;
      end else if (i_s_axi_araddr == fp_cmp_pkg::ADDR_LAST) begin
        o_s_axi_rdata <= {31'h0, last_result_reg};
      end else begin
        o_s_axi_rdata <= 32'h0;
        o_s_axi_rresp <= fp_cmp_pkg::RESP_SLVERR;
      end
    end else if (i_s_axi_rready) begin
      o_s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ===== hdl/fp_cmp_pkg.sv
// Purpose: Shared constants and types for the floating-point compare mask unit.
// Assumes: 32-bit AXI4-Lite register bus, 64-bit floating-point registers.
// Notes:   Offsets are byte addresses of aligned 32-bit words.
package fp_cmp_pkg;

  // ****************************************
  // Instruction encoding
  // ****************************************
  localparam logic [5:0] OPC_COP1 = 6'h11;
  localparam logic [4:0] FMT_SINGLE = 5'h14;
  localparam logic [4:0] FMT_DOUBLE = 5'h15;
  localparam int OPC_MSB = 31;
  localparam int OPC_LSB = 26;
  localparam int FMT_MSB = 25;
  localparam int FMT_LSB = 21;
  localparam int SRC2_LSB = 16;
  localparam int SRC1_LSB = 11;
  localparam int DEST_LSB = 6;
  localparam int FUNC_TOP = 5;
  localparam int COND_NEG = 4;
  localparam int COND_SIG = 3;
  localparam int COND_LT = 2;
  localparam int COND_EQ = 1;
  localparam int COND_UN = 0;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_COUNT = 8'h0c;
  localparam logic [7:0] ADDR_LAST = 8'h10;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [3:0] STATUS_RESET = 4'h0;
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam int CTRL_INV_EN = 0;
  localparam int CTRL_SUB_TRAP = 1;
  localparam int ST_INVALID = 0;
  localparam int ST_RSVD = 1;
  localparam int ST_UNUSABLE = 2;
  localparam int ST_UNIMPL = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // Exception codes
  // ****************************************
  typedef enum logic [2:0] {
    EXC_NONE = 3'b000,
    EXC_UNUSABLE = 3'b001,
    EXC_RSVD_INSTR = 3'b010,
    EXC_UNIMPL_OP = 3'b011,
    EXC_INVALID_OP = 3'b100
  } exc_code_t;

endpackage

// ===== hdl/fp_order_compare.sv
// Purpose: Ordering relations and NaN classes of two single or double operands.
// Assumes: Single operands sit in the low 32 bits of each 64-bit input.
// Notes:   Purely combinational.
`timescale 1ns/100ps
module fp_order_compare (
  // Operands
  input wire logic [63:0] i_op_a,
  input wire logic [63:0] i_op_b,
  input wire logic i_double,
  // Relations and classes
  output logic o_less,
  output logic o_equal,
  output logic o_unordered,
  output logic o_snan_any,
  output logic o_qnan_any,
  output logic o_sub_any
);

  logic [63:0] mag_a;
  logic [63:0] mag_b;
  logic sign_a;
  logic sign_b;
  logic [1:0] is_nan;
  logic [1:0] is_quiet;
  logic [1:0] is_sub;
  logic zero_both;

  always_comb begin
    if (i_double) begin
      sign_a = i_op_a[63];
      sign_b = i_op_b[63];
      mag_a = {1'b0, i_op_a[62:0]};
      mag_b = {1'b0, i_op_b[62:0]};
      is_nan[0] = (&i_op_a[62:52]) && (|i_op_a[51:0]);
      is_nan[1] = (&i_op_b[62:52]) && (|i_op_b[51:0]);
      is_quiet = {i_op_b[51], i_op_a[51]};
      is_sub[0] = ~(|i_op_a[62:52]) && (|i_op_a[51:0]);
      is_sub[1] = ~(|i_op_b[62:52]) && (|i_op_b[51:0]);
    end else begin
      sign_a = i_op_a[31];
      sign_b = i_op_b[31];
      mag_a = {33'h0, i_op_a[30:0]};
      mag_b = {33'h0, i_op_b[30:0]};
      is_nan[0] = (&i_op_a[30:23]) && (|i_op_a[22:0]);
      is_nan[1] = (&i_op_b[30:23]) && (|i_op_b[22:0]);
      is_quiet = {i_op_b[22], i_op_a[22]};
      is_sub[0] = ~(|i_op_a[30:23]) && (|i_op_a[22:0]);
      is_sub[1] = ~(|i_op_b[30:23]) && (|i_op_b[22:0]);
    end
    zero_both = (mag_a == 64'h0) && (mag_b == 64'h0);
    o_snan_any = |(is_nan & ~is_quiet);
    o_qnan_any = |(is_nan & is_quiet);
    o_sub_any = |is_sub;
    if (|is_nan) begin
      // Any NaN: only the unordered relation holds
      o_less = 1'b0; // RL2
      o_equal = 1'b0; // RL2
      o_unordered = 1'b1; // RL2
    end else begin
      o_unordered = 1'b0; // RL4
      if (zero_both) begin
        o_less = 1'b0; // RL13
        o_equal = 1'b1; // RL13
      end else begin
        o_equal = (sign_a == sign_b) && (mag_a == mag_b); // RL4
        if (sign_a != sign_b) begin
          o_less = sign_a; // RL4
        end else if (sign_a) begin
          o_less = mag_a > mag_b; // RL4
        end else begin
          o_less = mag_a < mag_b; // RL4
        end
      end
    end
  end

endmodule

// ===== sim/fp_cmp_properties.sv
// Purpose: Temporal checks on the compare unit's issue and result ports.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound to the unit from the bench top.
`timescale 1ns/100ps
module fp_cmp_checker (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // Issue side
  input wire logic i_issue_valid,
  input wire logic [31:0] i_instr,
  input wire logic i_fp_usable,
  // Result side
  input wire logic o_result_valid,
  input wire logic o_result_write,
  input wire logic [4:0] o_destination_register,
  input wire logic [63:0] o_result_data,
  input wire logic o_exc_valid,
  input wire logic [2:0] o_exc_code
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  logic go;
  assign go = i_issue_valid && i_fp_usable;
  a_answer_lat: assert property (i_issue_valid |=> o_result_valid)
    else $error("result strobe missing after issue");
  a_no_extra: assert property (!i_issue_valid |=> !o_result_valid)
    else $error("result strobe without issue");
  a_mask_full: assert property (o_result_write |-> !o_exc_valid &&
    (o_result_data == '1 || o_result_data == '0)) else $error("mask not uniform");
  a_unusable_exc: assert property (i_issue_valid && !i_fp_usable |=>
    o_exc_valid && o_exc_code == 3'h1) else $error("unusable not raised");
  a_bad_opcode: assert property (go && i_instr[31:26] != 6'h11 |=>
    o_exc_code == 3'h2) else $error("foreign opcode not refused");
  a_bad_format: assert property (go && !(i_instr[25:21] inside {5'h14, 5'h15})
    |=> o_exc_code == 3'h2) else $error("bad format not refused");
  a_rsvd_cond: assert property (go && i_instr[4] &&
    !(i_instr[2:0] inside {3'h1, 3'h2, 3'h3}) |=> o_exc_code == 3'h2)
    else $error("reserved condition not refused");
  a_dest_track: assert property (i_issue_valid ##1 o_result_write |->
    o_destination_register == $past(i_instr[10:6])) else $error("wrong destination");
  a_mask_hold: assert property (!o_result_write |-> $stable(o_result_data))
    else $error("mask changed without a write");
endmodule

// ===== sim/issue_model.sv
// Purpose: Issue stage stand-in that launches one instruction per request.
// Assumes: Requests arrive just after a rising edge.
// Notes: Idle instruction and operand fields toggle so no stale value can pass for a live one; the usable flag holds.
`timescale 1ns/100ps
module issue_model (
  // Clock
  input wire logic i_core_clk,
  // Bench request
  input wire logic i_req,
  input wire logic [31:0] i_req_instr,
  input wire logic [63:0] i_req_a,
  input wire logic [63:0] i_req_b,
  input wire logic i_req_use,
  // Issue port
  output logic o_issue_valid,
  output logic [31:0] o_instr,
  output logic [63:0] o_a,
  output logic [63:0] o_b,
  output logic o_fp_usable
);
  initial begin
    o_issue_valid = 1'b0;
    o_instr = '0;
    o_a = '0;
    o_b = '0;
    o_fp_usable = 1'b1;
  end
  always @(posedge i_core_clk) begin
    o_issue_valid <= i_req;
    if (i_req) begin
      o_instr <= i_req_instr;
      o_a <= i_req_a;
      o_b <= i_req_b;
      o_fp_usable <= i_req_use;
    end else begin
      o_instr <= ~o_instr;
      o_a <= ~o_a;
      o_b <= ~o_b;
    end
  end
endmodule

// ===== sim/tb.sv
// Purpose: Self-checking bench for the compare mask unit.
// Assumes: 40 MHz clock, registers on AXI4-Lite.
// Notes: Reference model runs at issue time, results checked in order.
`timescale 1ns/100ps
module tb;
  logic i_core_clk = 1'b0;
  logic i_reset = 1'b1;
  logic req = 1'b0, use_r = 1'b1, iv, fpu, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0;
  logic rry = 1'b0, awr, wr, bv, arr, rv, rvo, rwo, ev, irq, last = 1'b0;
  logic [31:0] req_i = '0, ins, wd = '0, rd;
  logic [63:0] req_a = '0, req_b = '0, fa, fb, dat;
  logic [7:0] awa = '0, ara = '0;
  logic [1:0] br, rr, ctrl = '0;
  logic [4:0] dst;
  logic [2:0] ec;
  logic [3:0] st = '0, ws = 4'hf;
  logic [9:0] e;
  logic [9:0] q[$];
  int n_fail = 0, checks = 0, seed = 7881, cnt = 0;

  initial forever #12.5 i_core_clk = ~i_core_clk;

  issue_model u_issue_model (.i_core_clk(i_core_clk), .i_req(req), .i_req_instr(req_i),
    .i_req_a(req_a), .i_req_b(req_b), .i_req_use(use_r), .o_issue_valid(iv),
    .o_instr(ins), .o_a(fa), .o_b(fb), .o_fp_usable(fpu));
  fp_compare_mask_unit u_fp_compare_mask_unit (.i_core_clk(i_core_clk), .i_reset(i_reset),
    .i_issue_valid(iv), .i_instr(ins), .i_first_source_operand(fa),
    .i_second_source_operand(fb), .i_fp_usable(fpu), .o_result_valid(rvo),
    .o_result_write(rwo), .o_destination_register(dst), .o_result_data(dat),
    .o_exc_valid(ev), .o_exc_code(ec), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
    .i_s_axi_awaddr(awa), .i_s_axi_wvalid(wv), .o_s_axi_wready(wr), .i_s_axi_wdata(wd),
    .i_s_axi_wstrb(ws), .o_s_axi_bvalid(bv), .i_s_axi_bready(bry), .o_s_axi_bresp(br),
    .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .i_s_axi_araddr(ara),
    .o_s_axi_rvalid(rv), .i_s_axi_rready(rry), .o_s_axi_rdata(rd), .o_s_axi_rresp(rr),
    .o_irq(irq));

  task automatic chk(input string nm, input logic [63:0] x, input logic [63:0] g);
    checks++;
    if (g !== x) begin
      $display("[ERR] %s expected %h seen %h", nm, x, g);
      n_fail++;
    end
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Write and read hold every channel until its own handshake edge
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] x);
    logic ha, hw, hb;
    logic [1:0] r;
    @(posedge i_core_clk);
    awv <= 1'b1; awa <= a; wv <= 1'b1; wd <= d; bry <= 1'b1;
    hb = 1'b0;
    while (!hb) begin
      @(negedge i_core_clk);
      ha = awv && awr; hw = wv && wr; hb = bv && bry; r = br;
      @(posedge i_core_clk);
      if (ha) awv <= 1'b0;
      if (hw) wv <= 1'b0;
    end
    bry <= 1'b0;
    chk("bresp", x, r);
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] x, input logic [1:0] xr);
    logic hr, hd;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge i_core_clk);
    arv <= 1'b1; ara <= a; rry <= 1'b1;
    hd = 1'b0;
    while (!hd) begin
      @(negedge i_core_clk);
      hr = arv && arr; hd = rv && rry; d = rd; r = rr;
      @(posedge i_core_clk);
      if (hr) arv <= 1'b0;
    end
    rry <= 1'b0;
    chk("rdata", x, d);
    chk("rresp", xr, r);
  endtask

  function automatic logic [2:0] cls(input logic [63:0] v, input logic d);
    logic f, e1, e0;
    f = d ? v[51:0] != 0 : v[22:0] != 0;
    e1 = d ? &v[62:52] : &v[30:23];
    e0 = d ? v[62:52] == 0 : v[30:23] == 0;
    return {e1 && f, e1 && f && (d ? v[51] : v[22]), e0 && f};
  endfunction

  // Operand mix: random, signed zero, quiet NaN, signalling NaN, subnormal
  function automatic logic [63:0] mk(input logic d);
    logic [63:0] r;
    r = {$random(seed), $random(seed)};
    if (r[2:0] == 1) r = r & (d ? 64'h8000_0000_0000_0000 : 64'hffff_ffff_8000_0000);
    if (r[2:0] inside {2, 3}) r = r | (d ? 64'h7ff8_0000_0000_0000 : 64'h7fc0_0000);
    if (r[2:0] == 3) r = (r & ~(d ? 64'h0008_0000_0000_0000 : 64'h0040_0000)) | 64'h1;
    if (r[2:0] == 4) r = (r & ~(d ? 64'h7ff0_0000_0000_0000 : 64'h7f80_0000)) | 64'h1;
    return r;
  endfunction

  task automatic issue(input int n);
    logic [31:0] r, s, i;
    logic [63:0] a, b, ma, mb;
    logic [4:0] c, fm;
    logic [2:0] ca, cb, code;
    logic d, z, lt, eq, un, inv, use_v;
    repeat (n) begin
      r = $random(seed); s = $random(seed);
      c = r[4:0];
      fm = (r[12:8] == 0) ? r[17:13] : (r[5] ? 5'h15 : 5'h14);
      d = fm == 5'h15;
      use_v = r[7:6] != 0;
      i = {(r[22:18] == 0) ? r[28:23] : 6'h11, fm, s[6:2], s[11:7], s[16:12], &r[31:29], c};
      a = mk(d);
      b = s[1:0] == 0 ? a : s[1:0] == 1 ?
        a ^ (d ? 64'h8000_0000_0000_0000 : 64'h8000_0000) : mk(d);
      ca = cls(a, d); cb = cls(b, d);
      ma = d ? a : {a[31], 32'h0, a[30:0]};
      mb = d ? b : {b[31], 32'h0, b[30:0]};
      z = ma[62:0] == 0 && mb[62:0] == 0;
      eq = z || ma == mb;
      lt = !z && (ma[63] != mb[63] ? ma[63] :
        (ma[63] ? ma[62:0] > mb[62:0] : ma[62:0] < mb[62:0]));
      un = ca[2] | cb[2];
      if (un) {lt, eq} = 2'b00;
      inv = (ca[2] && !ca[1]) || (cb[2] && !cb[1]) || (c[3] && (ca[1] || cb[1]));
      code = 3'h0;
      if (!use_v) code = 3'h1;
      else if (i[31:26] != 6'h11 || i[5] || !d && fm != 5'h14) code = 3'h2;
      else if (c[4] && !(c[2:0] inside {1, 2, 3})) code = 3'h2;
      else if ((ca[0] | cb[0]) && ctrl[1]) code = 3'h3;
      else if (inv) begin
        st[0] = 1'b1;
        if (ctrl[0]) code = 3'h4;
      end
      if (code != 0) st[code == 1 ? 2 : code == 2 ? 1 : code == 3 ? 3 : 0] = 1'b1;
      q.push_back({code, code == 0, i[10:6], c[4] ^ (c[2] & lt | c[1] & eq | c[0] & un)});
      if (code == 0) begin
        cnt++;
        last = q[$][0];
      end
      @(posedge i_core_clk);
      req <= 1'b1; req_i <= i; req_a <= a; req_b <= b; use_r <= use_v;
    end
    @(posedge i_core_clk);
    req <= 1'b0;
    repeat (4) @(posedge i_core_clk);
  endtask

  always @(negedge i_core_clk) begin
    if (!i_reset && rvo === 1'b1) begin
      e = q.pop_front();
      chk("exc_valid", e[9:7] != 0, ev);
      chk("exc_code", e[9:7], ec);
      chk("write", e[6], rwo);
      if (e[6]) begin
        chk("dest", e[5:1], dst);
        chk("mask", {64{e[0]}}, dat);
      end
    end
  end

  initial begin
    repeat (20000) @(posedge i_core_clk);
    n_fail++;
    tally_and_finish();
  end

  initial begin
    repeat (4) @(posedge i_core_clk);
    i_reset <= 1'b0;
    axr(8'h00, 32'h0, 2'h0);
    axr(8'h14, 32'h0, 2'h2);
    axw(8'h14, 32'hf, 2'h2);
    issue(300);
    axr(8'h04, {28'h0, st}, 2'h0);
    axr(8'h0c, cnt, 2'h0);
    axr(8'h10, {31'h0, last}, 2'h0);
    axw(8'h00, 32'h3, 2'h0);
    ctrl = 2'h3;
    issue(200);
    axr(8'h04, {28'h0, st}, 2'h0);
    // A write without byte strobes must leave the mask alone
    ws <= 4'h0;
    axw(8'h08, 32'hf, 2'h0);
    ws <= 4'hf;
    @(negedge i_core_clk);
    chk("irq", 1'b0, irq);
    axw(8'h08, 32'hf, 2'h0);
    @(negedge i_core_clk);
    chk("irq", st != 0, irq);
    axw(8'h04, 32'hf, 2'h0);
    axr(8'h04, 32'h0, 2'h0);
    @(negedge i_core_clk);
    chk("irq", 1'b0, irq);
    chk("pending", 0, q.size());
    tally_and_finish();
  end
endmodule

bind fp_compare_mask_unit fp_cmp_checker u_fp_cmp_checker (.i_core_clk(i_core_clk),
  .i_reset(i_reset), .i_issue_valid(i_issue_valid), .i_instr(i_instr),
  .i_fp_usable(i_fp_usable), .o_result_valid(o_result_valid),
  .o_result_write(o_result_write), .o_destination_register(o_destination_register),
  .o_result_data(o_result_data), .o_exc_valid(o_exc_valid), .o_exc_code(o_exc_code));
